// file: hdl/conn_mem_fill_prbs.sv
/*
  Fill engine for the upper/lower connection-memory words and the
  pseudo-random bit-error generator/checker of a slot_switch.
  Assumes: the transmit path owns the memory port whenever its
  read request is high; serial bits arrive on the same clock with a
  strobe naming the group, stream, channel they belong to.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "fill_prbs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module conn_mem_fill_prbs #(
  parameter int CHAN_W   = 9,
  parameter int STREAM_W = 3,
  parameter int GROUP_W  = 3,
  parameter int MEM_AW   = 15
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  input  wire logic                tx_cm_read,
  output logic                     cm_wr,
  output logic      [MEM_AW-1:0]   cm_addr,
  output logic      [2:0]          conn_mem_upper_word,
  output logic                     cm_lower_wr,
  input  wire logic                tx_bit_req,
  input  wire logic [2:0]          tx_chan_mode,
  output logic                     prbs_tx_bit,
  input  wire logic                rx_bit_valid,
  input  wire logic                rx_bit,
  input  wire logic [GROUP_W-1:0]  rx_group,
  input  wire logic [STREAM_W-1:0] rx_stream,
  input  wire logic [CHAN_W-1:0]   rx_channel
);

  localparam int SLOT_CNT_W = $clog2(`SLOT_CYCLES);

  logic [15:0]            control_r;
  logic [15:0]            fill_start_address_r;
  logic [15:0]            fill_end_address_r;
  logic [15:0]            error_test_input_select_r;
  logic [15:0]            error_count_view_r;
  logic [15:0]            error_count_live_r;
  fill_prbs_pkg::fill_state_t fill_state_r;
  logic [STREAM_W-1:0]    st_r;
  logic [CHAN_W-1:0]      ch_r;
  logic [GROUP_W-1:0]     grp_r;
  logic [SLOT_CNT_W-1:0]  slot_cnt_r;
  logic                   fill_go_d_r;
  logic                   test_go_d_r;
  logic                   clr_d_r;
  logic                   test_run_r;
  logic                   fill_done;
  logic                   fill_wr_nxt;
  logic [15:0]            reg_rdata_nxt;
  logic [STREAM_W-1:0]    st_nxt;
  logic [CHAN_W-1:0]      ch_nxt;
  logic [14:0]            tx_lfsr_r;
  logic [14:0]            rx_lfsr_r;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] prbs_step(input logic [14:0] s);
    prbs_step = {s[13:0], s[14] ^ s[13]};
  endfunction

  function automatic logic [STREAM_W-1:0] st_of(input logic [15:0] r);
    st_of = r[`ADDR_STREAM_HI:`ADDR_STREAM_LO];
  endfunction

  function automatic logic [CHAN_W-1:0] ch_of(input logic [15:0] r);
    ch_of = r[`ADDR_CHAN_HI:`ADDR_CHAN_LO];
  endfunction

  // Register index decode, used by the write paths; the read mux decodes with its own case
  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] idx);
    reg_hit = a == idx;
  endfunction

  wire wr_ctl   = reg_wr && reg_hit(reg_addr, `REG_CONTROL);
  wire fill_go  = control_r[`CTL_FILL_GO];
  wire go_rise  = fill_go && !fill_go_d_r;
  // Transmit reads always win; fill only uses cycles left free, and
  // its registered write follows one cycle later
  wire mem_slot = !tx_cm_read;
  wire fill_tick = mem_slot && slot_cnt_r == SLOT_CNT_W'(`SLOT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Control register. Completion clears go and pattern even against a
  // host write in the same cycle; the other bits still take the host
  // value, so a test command is never lost to a finishing fill.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_r <= 16'h0000;
    end else begin
      if (wr_ctl) begin
        control_r <= reg_wdata & `CTL_WMASK;
      end
      if (fill_done) begin
        control_r[`CTL_FILL_GO] <= 1'b0;
        control_r[`CTL_PATTERN_HI:`CTL_PATTERN_LO] <= 3'h0;
      end
    end
  end

  // Reserved bits forced on write, so a read shows what the engine uses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_start_address_r      <= `FILL_START_RESET;
      fill_end_address_r        <= `FILL_END_RESET;
      error_test_input_select_r <= `TEST_SELECT_RESET;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, `REG_FILL_START)) begin
        fill_start_address_r <= {1'b0, reg_wdata[14:0]};
      end
      if (reg_hit(reg_addr, `REG_FILL_END)) begin
        fill_end_address_r <= {4'hF, reg_wdata[11:0]};
      end
      if (reg_hit(reg_addr, `REG_TEST_SELECT)) begin
        error_test_input_select_r <= {1'b0, reg_wdata[14:0]};
      end
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    reg_rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CONTROL:     reg_rdata_nxt = control_r;
        `REG_FILL_START:  reg_rdata_nxt = fill_start_address_r;
        `REG_FILL_END:    reg_rdata_nxt = fill_end_address_r;
        `REG_TEST_SELECT: reg_rdata_nxt = error_test_input_select_r;
        `REG_ERR_VIEW:    reg_rdata_nxt = error_count_view_r;
        `REG_STATUS:      reg_rdata_nxt = {13'h0000, test_run_r, fill_state_r};
        default:          reg_rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fill engine. Whole fill uses every free slot so the whole
  // memory is covered in well under two frames.
  wire [STREAM_W-1:0] st_s = st_of(fill_start_address_r);
  wire [STREAM_W-1:0] st_e = st_of(fill_end_address_r);
  wire [CHAN_W-1:0]   ch_s = ch_of(fill_start_address_r);
  wire [CHAN_W-1:0]   ch_e = ch_of(fill_end_address_r);
  wire whole_last = (&st_r) && (&ch_r) && (&grp_r);
  wire group_last = st_r == st_e && ch_r == ch_e;
  wire whole_step = mem_slot;

  // Window stepping: streams inner, channels outer. Each field wraps at
  // its own width, so an end below the start runs over the top.
  always_comb begin
    st_nxt = st_r + 1'b1;
    ch_nxt = ch_r;
    if (st_r == st_e) begin
      st_nxt = st_s;
      ch_nxt = ch_r + 1'b1;
    end
  end

  always_comb begin
    fill_done = 1'b0;
    case (fill_state_r)
      fill_prbs_pkg::FILL_WHOLE: fill_done = whole_step && whole_last;
      fill_prbs_pkg::FILL_GROUP: fill_done = fill_tick && group_last;
      default:                   fill_done = 1'b0;
    endcase
  end

  // One qualifier feeds both words so upper and lower writes align
  always_comb begin
    fill_wr_nxt = 1'b0;
    case (fill_state_r)
      fill_prbs_pkg::FILL_WHOLE: fill_wr_nxt = fill_go && whole_step;
      fill_prbs_pkg::FILL_GROUP: fill_wr_nxt = fill_go && fill_tick;
      default:                   fill_wr_nxt = 1'b0;
    endcase
  end

  // Go delayed one cycle for the start edge; resets low like the bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_go_d_r <= 1'b0;
    end else begin
      fill_go_d_r <= fill_go;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_state_r <= fill_prbs_pkg::FILL_IDLE;
      st_r         <= '0;
      ch_r         <= '0;
      grp_r        <= '0;
      slot_cnt_r   <= '0;
    end else if (!fill_go) begin
      // Go cleared by the host: back to idle at once, no further writes
      fill_state_r <= fill_prbs_pkg::FILL_IDLE;
    end else begin
      case (fill_state_r)
        fill_prbs_pkg::FILL_IDLE: begin
          if (go_rise) begin
            slot_cnt_r <= '0;
            if (control_r[`CTL_WHOLE_FILL]) begin
              fill_state_r <= fill_prbs_pkg::FILL_WHOLE;
              st_r  <= '0;
              ch_r  <= '0;
              grp_r <= '0;
            end else begin
              fill_state_r <= fill_prbs_pkg::FILL_GROUP;
              st_r  <= st_s;
              ch_r  <= ch_s;
              grp_r <= fill_start_address_r[`ADDR_GROUP_HI:`ADDR_GROUP_LO];
            end
          end
        end
        fill_prbs_pkg::FILL_WHOLE: begin
          if (whole_step) begin
            // Stream counts fastest, then channel, then group
            {grp_r, ch_r, st_r} <= {grp_r, ch_r, st_r} + 1'b1;
            if (whole_last) begin
              fill_state_r <= fill_prbs_pkg::FILL_IDLE;
            end
          end
        end
        fill_prbs_pkg::FILL_GROUP: begin
          if (mem_slot) begin
            slot_cnt_r <= slot_cnt_r + 1'b1;
          end
          if (fill_tick) begin
            if (group_last) begin
              fill_state_r <= fill_prbs_pkg::FILL_IDLE;
            end else begin
              st_r <= st_nxt;
              ch_r <= ch_nxt;
            end
          end
        end
        default: fill_state_r <= fill_prbs_pkg::FILL_IDLE;
      endcase
    end
  end

  // Memory-side outputs registered; address and pattern ride with the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cm_wr               <= 1'b0;
      cm_lower_wr         <= 1'b0;
      cm_addr             <= '0;
      conn_mem_upper_word <= 3'h0;
    end else begin
      cm_wr       <= fill_wr_nxt;
      cm_lower_wr <= fill_wr_nxt && control_r[`CTL_CLEAR_LOWER];
      cm_addr <= MEM_AW'({grp_r, st_r, ch_r});
      conn_mem_upper_word <= control_r[`CTL_PATTERN_HI:`CTL_PATTERN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-error test: generator, checker and counters
  wire prbs_rst     = control_r[`CTL_PRBS_RESTART];
  wire test_go      = control_r[`CTL_TEST_GO];
  wire err_clr      = control_r[`CTL_ERR_CLEAR];
  // Edge detectors reset low like the bits, so reset gives no false edge
  wire test_go_rise = test_go && !test_go_d_r;
  wire clr_rise     = err_clr && !clr_d_r;
  // Only the one selected location feeds the checker
  wire rx_loc_hit   = {rx_group, rx_stream, rx_channel} == error_test_input_select_r[14:0];
  wire rx_hit       = rx_bit_valid && test_run_r && rx_loc_hit;
  wire rx_err       = rx_hit && (rx_bit != rx_lfsr_r[14]);

  // Checker runs from the go edge until go is cleared
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_go_d_r <= 1'b0;
      clr_d_r     <= 1'b0;
      test_run_r  <= 1'b0;
    end else begin
      test_go_d_r <= test_go;
      clr_d_r     <= err_clr;
      if (test_go_rise) begin
        test_run_r <= 1'b1;
      end else if (!test_go) begin
        test_run_r <= 1'b0;
      end
    end
  end

  // Generator x^15 + x^14 + 1, MSB first; restart holds it at the seed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lfsr_r   <= `PRBS_SEED;
      prbs_tx_bit <= 1'b0;
    end else if (prbs_rst) begin
      tx_lfsr_r   <= `PRBS_SEED;
      prbs_tx_bit <= 1'b0;
    end else if (tx_bit_req && tx_chan_mode == `MODE_PRBS_TX) begin
      prbs_tx_bit <= tx_lfsr_r[14];
      tx_lfsr_r   <= prbs_step(tx_lfsr_r);
    end
  end

  // Reference copy steps only on bits of the selected location
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lfsr_r <= `PRBS_SEED;
    end else if (prbs_rst || test_go_rise) begin
      rx_lfsr_r <= `PRBS_SEED;
    end else if (rx_hit) begin
      rx_lfsr_r <= prbs_step(rx_lfsr_r);
    end
  end

  // Count is free-running modulo 2^16, no flag on wrap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_count_live_r <= 16'h0000;
    end else if (clr_rise) begin
      error_count_live_r <= 16'h0000;
    end else if (rx_err) begin
      error_count_live_r <= error_count_live_r + 16'h0001;
    end
  end

  // Snapshot of the live count; the written data are dropped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_count_view_r <= 16'h0000;
    end else if (reg_wr && reg_hit(reg_addr, `REG_ERR_VIEW)) begin
      error_count_view_r <= error_count_live_r;
    end
  end

endmodule

// file: hdl/fill_prbs_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  connection-memory fill engine and the bit-error test block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef FILL_PRBS_DEFS_SVH
`define FILL_PRBS_DEFS_SVH

`define REG_CONTROL        4'h0
`define REG_FILL_START     4'h1
`define REG_FILL_END       4'h2
`define REG_TEST_SELECT    4'h3
`define REG_ERR_VIEW       4'h4
`define REG_STATUS         4'h5

`define CTL_PRBS_RESTART   11
`define CTL_ERR_CLEAR      10
`define CTL_TEST_GO        9
`define CTL_WHOLE_FILL     8
`define CTL_PATTERN_HI     7
`define CTL_PATTERN_LO     5
`define CTL_FILL_GO        4
`define CTL_CLEAR_LOWER    3
`define CTL_WMASK          16'h0FF8

`define ADDR_GROUP_HI      14
`define ADDR_GROUP_LO      12
`define ADDR_STREAM_HI     11
`define ADDR_STREAM_LO     9
`define ADDR_CHAN_HI       8
`define ADDR_CHAN_LO       0

`define FILL_START_RESET   16'h0000
`define FILL_END_RESET     16'hF000
`define TEST_SELECT_RESET  16'h0000

`define SLOT_CYCLES        32
`define PRBS_SEED          15'h7FFF
`define MODE_PRBS_TX       3'h5

`endif

// file: hdl/fill_prbs_pkg.sv
/*
  Types shared by the fill and bit-error test block.
  Assumes no other package.
*/
package fill_prbs_pkg;
  typedef enum logic [1:0] {
    FILL_IDLE  = 2'b00,
    FILL_WHOLE = 2'b01,
    FILL_GROUP = 2'b10
  } fill_state_t;
endpackage

// file: tb/conn_mem_fill_prbs_test.sv
/*
  Self-checking bench for the fill engine and bit-error test.
  Assumes the monitor is bound and the transmit model in place.
*/
`include "fill_prbs_defs.svh"

module conn_mem_fill_prbs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        tx_cm_read;
  logic        cm_wr;
  logic [14:0] cm_addr;
  logic [2:0]  upper;
  logic        cm_lower_wr;
  logic        tx_bit_req;
  logic [2:0]  tx_chan_mode;
  logic        prbs_tx_bit;
  logic        rx_bit_valid;
  logic        rx_bit;
  logic [14:0] rx_loc;
  logic [15:0] d;
  logic [14:0] lf;
  logic        bits [0:39];
  int          err_count;
  int          num_checks;
  int          i;
  int          bad;

  always #2 ref_clk = ~ref_clk;

  conn_mem_fill_prbs uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_cm_read(tx_cm_read),
    .cm_wr(cm_wr), .cm_addr(cm_addr), .conn_mem_upper_word(upper),
    .cm_lower_wr(cm_lower_wr), .tx_bit_req(tx_bit_req), .tx_chan_mode(tx_chan_mode),
    .prbs_tx_bit(prbs_tx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_group(rx_loc[14:12]), .rx_stream(rx_loc[11:9]), .rx_channel(rx_loc[8:0])
  );

  tx_path_model u_tx (
    .ref_clk(ref_clk), .rst_b(rst_b), .tx_cm_read(tx_cm_read),
    .tx_bit_req(tx_bit_req), .tx_chan_mode(tx_chan_mode)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    int k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
    end while (s !== 1'b1 && k < lim);
    if (s !== 1'b1) begin
      err_count++;
      $display("[FAIL] handshake expected 1 seen %b", s);
      give_verdict;
    end
  endtask

  task no_wr(input int n);
    int k;
    int c;
    c = 0;
    for (k = 0; k < n; k++) begin
      @(posedge ref_clk);
      #1 if (cm_wr === 1'b1) c++;
    end
    chk("idle writes", 16'h0000, 16'(c));
  endtask

  // Released data line shows the inverse, so stale bits never look valid
  task rx_send(input logic b, input logic [14:0] loc);
    @(posedge ref_clk);
    rx_bit_valid <= 1'b1;
    rx_bit <= b;
    rx_loc <= loc;
    @(posedge ref_clk);
    rx_bit_valid <= 1'b0;
    rx_bit <= ~b;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_loc = 15'h0000;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`REG_FILL_START, d);
    chk("start reset", 16'h0000, d);
    rd(`REG_FILL_END, d);
    chk("end reset", 16'hF000, d);
    rd(4'h6, d);
    chk("unmapped", 16'h0000, d);
    wr(`REG_FILL_START, 16'hFFFF);
    rd(`REG_FILL_START, d);
    chk("start bits", 16'h7FFF, d);
    wr(`REG_FILL_END, 16'h0000);
    rd(`REG_FILL_END, d);
    chk("end bits", 16'hF000, d);
    wr(`REG_TEST_SELECT, 16'hFFFF);
    rd(`REG_TEST_SELECT, d);
    chk("select bits", 16'h7FFF, d);
    // Window wraps both coordinates: streams 6..1, channels 510..1
    wr(`REG_FILL_START, 16'h1DFE);
    wr(`REG_FILL_END, 16'hF201);
    wr(`REG_CONTROL, 16'h00B8);
    for (i = 0; i < 16; i++) begin
      wait_hi(cm_wr, 200);
      chk("win addr", {1'b0, 3'h1, 3'(6 + i % 4), 9'(510 + i / 4)}, {1'b0, cm_addr});
      chk("win data", 16'h0005, {13'h0, upper});
      chk("win lower", 16'h0001, {15'h0, cm_lower_wr});
    end
    no_wr(80);
    rd(`REG_CONTROL, d);
    chk("win done", 16'h0008, d);
    wr(`REG_CONTROL, 16'h0170);
    bad = 0;
    for (i = 0; i < 32768; i++) begin
      wait_hi(cm_wr, 20);
      if (upper !== 3'h3 || cm_lower_wr !== 1'b0) bad++;
    end
    chk("whole data", 16'h0000, 16'(bad));
    chk("whole last", 16'h7FFF, {1'b0, cm_addr});
    no_wr(40);
    rd(`REG_CONTROL, d);
    chk("whole done", 16'h0100, d);
    wr(`REG_CONTROL, 16'h0010);
    wait_hi(cm_wr, 100);
    rd(`REG_STATUS, d);
    chk("fill busy", 16'h0002, d);
    wr(`REG_CONTROL, 16'h0000);
    no_wr(100);
    wr(`REG_TEST_SELECT, 16'h2607);
    wr(`REG_CONTROL, 16'h0E00);
    wr(`REG_CONTROL, 16'h0200);
    bad = 0;
    for (i = 0; i < 40; i++) begin
      wait_hi(tx_bit_req, 10);
      @(posedge ref_clk);
      #1 bits[i] = prbs_tx_bit;
      if (i >= 15 && bits[i] !== (bits[i - 14] ^ bits[i - 15])) bad++;
    end
    if (bits.sum() with (int'(item)) == 0) bad++;
    chk("prbs recur", 16'h0000, 16'(bad));
    rd(`REG_STATUS, d);
    chk("test running", 16'h0004, d);
    lf = `PRBS_SEED;
    for (i = 0; i < 60; i++) begin
      rx_send(lf[14] ^ (i % 20 == 10), 15'h2607);
      rx_send(~lf[14], 15'h2608);
      lf = {lf[13:0], lf[14] ^ lf[13]};
    end
    wr(`REG_ERR_VIEW, 16'hABCD);
    rd(`REG_ERR_VIEW, d);
    chk("err count", 16'h0003, d);
    wr(`REG_CONTROL, 16'h0600);
    wr(`REG_ERR_VIEW, 16'h5555);
    rd(`REG_ERR_VIEW, d);
    chk("err cleared", 16'h0000, d);
    give_verdict;
  end
endmodule

// file: tb/fill_prbs_monitor.sv
/*
  Port checker for the fill and bit-error test block.
  Assumes binding onto conn_mem_fill_prbs; sees its ports only.
*/
`include "fill_prbs_defs.svh"

module fill_prbs_monitor #(
  parameter int MEM_AW = 15
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              tx_cm_read,
  input wire logic              cm_wr,
  input wire logic [MEM_AW-1:0] cm_addr,
  input wire logic [2:0]        conn_mem_upper_word,
  input wire logic              cm_lower_wr
);
  logic        whole_r;
  logic        clr_r;
  logic        seen_r;
  logic [2:0]  pat_r;
  logic [5:0]  free_r;
  logic [14:0] last_r;
  wire         ctl_wr = reg_wr && reg_addr == `REG_CONTROL;

  // Whole fill order: stream fastest, then channel, then group
  function automatic logic [14:0] step(input logic [14:0] a);
    logic [14:0] x;
    x = {a[14:12], a[8:0], a[11:9]} + 15'h0001;
    return {x[14:12], x[2:0], x[11:3]};
  endfunction

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      whole_r <= 1'b0;
      clr_r <= 1'b0;
      pat_r <= 3'h0;
    end else if (ctl_wr) begin
      whole_r <= reg_wdata[`CTL_WHOLE_FILL];
      clr_r <= reg_wdata[`CTL_CLEAR_LOWER];
      pat_r <= reg_wdata[`CTL_PATTERN_HI:`CTL_PATTERN_LO];
    end
  end

  // Gap counts free cycles only, as the memory is shared with transmit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_r <= 1'b0;
      free_r <= 6'h00;
      last_r <= 15'h0000;
    end else begin
      seen_r <= cm_wr || (seen_r && !ctl_wr);
      if (cm_wr) begin
        free_r <= 6'h00;
        last_r <= cm_addr[14:0];
      end else if (!tx_cm_read && free_r != 6'h3F) begin
        free_r <= free_r + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_start_top_zero:
    assert property (reg_rd && reg_addr == `REG_FILL_START |=> !reg_rdata[15])
    else $error("fill start bit 15 read as one");
  a_end_top_ones:
    assert property (reg_rd && reg_addr == `REG_FILL_END |=> reg_rdata[15:12] == 4'hF)
    else $error("fill end top bits not all ones");
  a_sel_top_zero:
    assert property (reg_rd && reg_addr == `REG_TEST_SELECT |=> !reg_rdata[15])
    else $error("test select bit 15 read as one");
  a_tx_read_first:
    assert property (tx_cm_read |=> !cm_wr)
    else $error("fill wrote while transmit owned memory");
  a_lower_word_clear:
    assert property (cm_wr || cm_lower_wr |-> cm_wr && cm_lower_wr == clr_r)
    else $error("lower word write disagrees with clear bit");
  a_pattern_value:
    assert property (cm_wr |-> conn_mem_upper_word == pat_r)
    else $error("fill data differs from pattern");
  a_whole_addr_step:
    assert property (cm_wr && whole_r && seen_r |-> cm_addr[14:0] == step(last_r))
    else $error("whole fill address out of order");
  a_window_gap:
    assert property (cm_wr && !whole_r && seen_r |-> free_r >= 6'd31 && free_r <= 6'd32)
    else $error("window fill write spacing wrong");

  c_window: cover property (cm_wr && !whole_r && seen_r);
  c_whole: cover property (cm_wr && whole_r && seen_r);
  c_lower: cover property (cm_lower_wr);
  c_view: cover property (reg_rd && reg_addr == `REG_ERR_VIEW);
endmodule

bind conn_mem_fill_prbs fill_prbs_monitor #(.MEM_AW(MEM_AW)) u_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_cm_read(tx_cm_read),
  .cm_wr(cm_wr), .cm_addr(cm_addr), .conn_mem_upper_word(conn_mem_upper_word),
  .cm_lower_wr(cm_lower_wr)
);

// file: tb/tx_path_model.sv
/*
  Transmit path beside the block: memory reads and bit requests.
  Assumes one clock shared with the block.
*/
`include "fill_prbs_defs.svh"

module tx_path_model (
  input wire logic  ref_clk,
  input wire logic  rst_b,
  output logic       tx_cm_read,
  output logic       tx_bit_req,
  output logic [2:0] tx_chan_mode
);
  logic [1:0] phase_r;

  // One read slot in four keeps fills slow but always moving
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 2'h0;
      tx_cm_read <= 1'b0;
      tx_bit_req <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1;
      tx_cm_read <= phase_r == 2'h2;
      tx_bit_req <= phase_r == 2'h0;
    end
  end

  assign tx_chan_mode = tx_bit_req ? `MODE_PRBS_TX : 3'h0;
endmodule
